// ==== fdcs_params.svh ====
`ifndef FDCS_PARAMS_SVH
`define FDCS_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define FDCS_OFF_CMD       8'h00
`define FDCS_OFF_STATUS    8'h04
`define FDCS_OFF_CTRL      8'h08

// Control register fields and reset values.
`define FDCS_CTRL_DDEN     0
`define FDCS_CTRL_HLD      1
`define FDCS_CTRL_RST      2'h0
`define FDCS_STATUS_RST    8'h80
`define FDCS_CMD_RST       8'h00

// Forced-interrupt command code in the upper nibble.
`define FDCS_FORCE_CODE    4'hD

// AXI responses.
`define FDCS_RESP_OKAY     2'b00
`define FDCS_RESP_SLVERR   2'b10

// Timing: settle delay in ms, clock in kHz, busy latency limits in clocks.
`define FDCS_SETTLE_MS     15
`define FDCS_CLK_KHZ       100000
`define FDCS_BUSY_MAX_SD   24
`define FDCS_BUSY_MAX_DD   12

`endif

// ==== fdcs_pkg.sv ====
package fdcs_pkg;

    typedef enum logic [2:0] {
        CL_SEEK   = 3'b000,
        CL_RD_SEC = 3'b001,
        CL_WR_SEC = 3'b010,
        CL_RD_ADR = 3'b011,
        CL_RD_TRK = 3'b100,
        CL_WR_TRK = 3'b101,
        CL_FORCED = 3'b110
    } fdcs_class_t;

endpackage

// ==== fdcs_flag.sv ====
`timescale 1ns/10ps
module fdcs_flag (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic srst,
    // Set and clear.
    input  wire logic set,
    input  wire logic clr,
    // Flag.
    output logic      flag
);

    // A set in the cycle of a clear wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end

endmodule

// ==== fdcs_settle.sv ====
`timescale 1ns/10ps
module fdcs_settle #(
    parameter int unsigned CYCLES = 1500000
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic srst,
    // Request and bypass.
    input  wire logic start,
    input  wire logic skip,
    // Completion pulse.
    output logic      done
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= '0;
            done   <= 1'b0;
        end else if (start) begin
            cnt_ff <= skip ? '0 : CW'(CYCLES);
            done   <= skip;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
            done   <= (cnt_ff == CW'(1));
        end else begin
            done   <= 1'b0;
        end
    end

endmodule

// ==== fdcs_status_ctrl.sv ====
// Function
// R01: Only forced-interrupt commands are taken while busy; others need busy clear.
// R02: A forced interrupt during a command suspends it, then follows its flags; the code aborts it via CMD_ABORT and clears busy.
// R03: Forced interrupt request clears on status read or all-zero-flag forced command.
// R04: Status bit 0 shows busy during seek, sector and track commands.
// R05: A forced interrupt clears busy.
// R06: Forced interrupt when idle gives seek layout with bits 4, 3, 0 zero.
// R07: Forced interrupt while busy keeps the interrupted command's status layout.
// R08: Status layout depends on command class, with fixed zero bits per class.
// R09: Bit 7 is not-ready: drive not ready or reset asserted.
// R10: Bit 6 is inverted write protect; seek bit 2 is inverted track zero; the code keeps bit 6 zero for read commands.
// R11: Seek bit 5 is head load output AND head load timing input.
// R12: Seek bit 1 is inverted index pulse input.
// R13: Seek bit 4 flags verify failure, cleared at next command start.
// R14: Bit 3 flags CRC error, cleared at next command start; the code shows it for seek, sector and read address only.
// R15: Busy is set within 24 clocks single density, 12 double density.
// R16: Read commands: bit 5 is deleted data mark, cleared at next start; the code shows it for read sector only.
// R17: Write commands: bit 5 flags abort by write fault.
// R18: Sector and track commands: bit 4 flags record not found; the code shows it for sector and read address only.
// R19: Sector and track commands: bit 2 flags lost data; the code keeps bit 2 zero for write track.
// R20: Sector and track commands: bit 1 follows the data request output.
// R21: Head settle delay is 15 ms, skipped when test input is low.
// R22: Host repeats sector sequence while formatting, then gap fill until interrupt.
`timescale 1ns/10ps
`include "fdcs_params.svh"
module fdcs_status_ctrl
    import fdcs_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = `FDCS_SETTLE_MS * `FDCS_CLK_KHZ
) (
    // Clock and reset.
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    // AXI4-Lite slave.
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Drive inputs, pin levels.
    input  wire logic        READY_IN,
    input  wire logic        WRITE_PROTECT_IN,
    input  wire logic        TRACK_ZERO_IN,
    input  wire logic        INDEX_PULSE_IN,
    input  wire logic        HEAD_LOAD_TIMING_IN,
    input  wire logic        TEST_IN,
    // Sequencer and data path events.
    input  wire logic        DATA_REQUEST_IN,
    input  wire logic        VERIFY_FAIL,
    input  wire logic        CRC_ERROR,
    input  wire logic        RECORD_NOT_FOUND,
    input  wire logic        LOST_DATA,
    input  wire logic        DELETED_MARK,
    input  wire logic        WRITE_FAULT,
    input  wire logic        CMD_DONE,
    input  wire logic        SETTLE_REQ,
    // Outputs to sequencer and drive.
    output logic             CMD_START,
    output logic [7:0]       CMD_CODE,
    output logic             CMD_ABORT,
    output logic             SETTLE_DONE,
    output logic             BUSY_OUT,
    output logic             HEAD_LOAD_OUT,
    output logic             INTERRUPT_REQUEST_OUT
);

    localparam int BUSY_SD = `FDCS_BUSY_MAX_SD;
    localparam int BUSY_DD = `FDCS_BUSY_MAX_DD;

    logic        awready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  ctrl_ff;
    logic [7:0]  cmd_ff;
    logic        busy_ff;
    logic        irq_ff;
    logic        start_ff;
    logic        abort_ff;
    logic [3:0]  cond_ff;
    logic        ready_q_ff;
    logic        index_q_ff;
    logic [7:0]  status_ff;
    logic [7:0]  nxt_status;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;
    fdcs_class_t class_ff;
    fdcs_class_t nxt_class;

    logic aw_fire;
    logic wr_do;
    logic ar_fire;
    logic rd_do;
    logic cmd_wr;
    logic is_force;
    logic cmd_acc;
    logic cmd_start;
    logic force_acc;
    logic stat_rd;
    logic cond_hit;
    logic irq_set;
    logic irq_clr;
    logic f_verify;
    logic f_crc;
    logic f_rnf;
    logic f_mark;
    logic f_lost;

    // AXI write channel: address and data are taken together, one at a time.
    assign aw_fire = S_AXI_AWVALID && S_AXI_WVALID && !awready_ff && !bvalid_ff;
    assign wr_do   = awready_ff;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            awready_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `FDCS_RESP_OKAY;
        end else begin
            awready_ff <= aw_fire;
            if (wr_do) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (S_AXI_AWADDR == `FDCS_OFF_CMD || S_AXI_AWADDR == `FDCS_OFF_CTRL)
                             ? `FDCS_RESP_OKAY : `FDCS_RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ctrl_ff <= `FDCS_CTRL_RST;
        end else if (wr_do && S_AXI_AWADDR == `FDCS_OFF_CTRL && S_AXI_WSTRB[0]) begin
            ctrl_ff <= S_AXI_WDATA[1:0];
        end
    end

    // AXI read channel.
    assign ar_fire = S_AXI_ARVALID && !arready_ff && !rvalid_ff;
    assign rd_do   = arready_ff;
    assign stat_rd = rd_do && S_AXI_ARADDR == `FDCS_OFF_STATUS;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `FDCS_RESP_OKAY;
        unique case (S_AXI_ARADDR)
            `FDCS_OFF_CMD:    nxt_rdata = {24'h00_0000, cmd_ff};
            `FDCS_OFF_STATUS: nxt_rdata = {24'h00_0000, status_ff};
            `FDCS_OFF_CTRL:   nxt_rdata = {30'h0000_0000, ctrl_ff};
            default:          nxt_rresp = `FDCS_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= `FDCS_RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            arready_ff <= ar_fire;
            if (rd_do) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= nxt_rresp;
                rdata_ff  <= nxt_rdata;
            end else if (S_AXI_RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Command acceptance.
    assign cmd_wr    = wr_do && S_AXI_AWADDR == `FDCS_OFF_CMD && S_AXI_WSTRB[0];
    assign is_force  = S_AXI_WDATA[7:4] == `FDCS_FORCE_CODE;
    assign cmd_acc   = cmd_wr && (is_force || !busy_ff); // R01
    assign cmd_start = cmd_acc && !is_force;
    assign force_acc = cmd_acc && is_force;

    always_comb begin
        nxt_class = class_ff;
        if (cmd_start) begin
            unique casez (S_AXI_WDATA[7:4])
                4'b0???: nxt_class = CL_SEEK;
                4'b100?: nxt_class = CL_RD_SEC;
                4'b101?: nxt_class = CL_WR_SEC;
                4'b1100: nxt_class = CL_RD_ADR;
                4'b1110: nxt_class = CL_RD_TRK;
                4'b1111: nxt_class = CL_WR_TRK;
                default: nxt_class = class_ff;
            endcase
        end else if (force_acc && !busy_ff) begin
            nxt_class = CL_FORCED; // R06
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            class_ff <= CL_SEEK;
            cmd_ff   <= `FDCS_CMD_RST;
            busy_ff  <= 1'b0;
            start_ff <= 1'b0;
            abort_ff <= 1'b0;
            cond_ff  <= 4'h0;
        end else begin
            class_ff <= nxt_class; // R07
            start_ff <= cmd_start;
            abort_ff <= force_acc && busy_ff; // R02
            if (cmd_acc) begin
                cmd_ff <= S_AXI_WDATA[7:0];
            end
            if (force_acc) begin
                cond_ff <= S_AXI_WDATA[3:0];
            end
            if (cmd_start) begin
                busy_ff <= 1'b1; // R15
            end else if (force_acc || CMD_DONE) begin
                busy_ff <= 1'b0; // R05
            end
        end
    end

    // Interrupt request and forced-interrupt conditions.
    assign cond_hit = (cond_ff[2] && index_q_ff && !INDEX_PULSE_IN)
                   || (cond_ff[1] && ready_q_ff && !READY_IN)
                   || (cond_ff[0] && !ready_q_ff && READY_IN); // R02
    assign irq_set  = (CMD_DONE && busy_ff) || (force_acc && S_AXI_WDATA[3]) || cond_hit;
    assign irq_clr  = stat_rd || (force_acc && S_AXI_WDATA[3:0] == 4'h0); // R03

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            irq_ff     <= 1'b0;
            ready_q_ff <= 1'b0;
            index_q_ff <= 1'b1;
        end else begin
            ready_q_ff <= READY_IN;
            index_q_ff <= INDEX_PULSE_IN;
            if (irq_set) begin
                irq_ff <= 1'b1;
            end else if (irq_clr) begin
                irq_ff <= 1'b0; // R03
            end
        end
    end

    // Sticky error flags, cleared when the next command starts.
    fdcs_flag u_flag_verify (
        .clk  (CLK_SYS),
        .srst (SRST),
        .set  (VERIFY_FAIL && busy_ff),
        .clr  (cmd_start),
        .flag (f_verify)
    ); // R13
    fdcs_flag u_flag_crc (
        .clk  (CLK_SYS),
        .srst (SRST),
        .set  (CRC_ERROR && busy_ff),
        .clr  (cmd_start),
        .flag (f_crc)
    ); // R14
    fdcs_flag u_flag_rnf (
        .clk  (CLK_SYS),
        .srst (SRST),
        .set  (RECORD_NOT_FOUND && busy_ff),
        .clr  (cmd_start),
        .flag (f_rnf)
    ); // R18
    fdcs_flag u_flag_mark (
        .clk  (CLK_SYS),
        .srst (SRST),
        .set  ((DELETED_MARK || WRITE_FAULT) && busy_ff),
        .clr  (cmd_start),
        .flag (f_mark)
    ); // R16 R17
    fdcs_flag u_flag_lost (
        .clk  (CLK_SYS),
        .srst (SRST),
        .set  (LOST_DATA && busy_ff),
        .clr  (cmd_start),
        .flag (f_lost)
    ); // R19

    // Status composition per command class.
    always_comb begin
        nxt_status    = 8'h00;
        nxt_status[7] = !READY_IN; // R09
        nxt_status[0] = busy_ff; // R04
        unique case (class_ff)
            CL_SEEK, CL_FORCED: begin
                nxt_status[6] = !WRITE_PROTECT_IN; // R10
                nxt_status[5] = ctrl_ff[`FDCS_CTRL_HLD] && HEAD_LOAD_TIMING_IN; // R11
                nxt_status[4] = f_verify && class_ff == CL_SEEK; // R13
                nxt_status[3] = f_crc && class_ff == CL_SEEK; // R14
                nxt_status[2] = !TRACK_ZERO_IN; // R10
                nxt_status[1] = !INDEX_PULSE_IN; // R12
                nxt_status[0] = busy_ff && class_ff == CL_SEEK; // R06
            end
            CL_RD_SEC: begin
                nxt_status[5:1] = {f_mark, f_rnf, f_crc, f_lost, DATA_REQUEST_IN}; // R08 R16
            end
            CL_WR_SEC: begin
                nxt_status[6:1] = {!WRITE_PROTECT_IN, f_mark, f_rnf, f_crc, f_lost,
                                   DATA_REQUEST_IN}; // R17 R18
            end
            CL_RD_ADR: begin
                nxt_status[4:1] = {f_rnf, f_crc, f_lost, DATA_REQUEST_IN}; // R08
            end
            CL_RD_TRK: begin
                nxt_status[2:1] = {f_lost, DATA_REQUEST_IN}; // R19 R20
            end
            CL_WR_TRK: begin
                nxt_status[6:5] = {!WRITE_PROTECT_IN, f_mark}; // R08
                nxt_status[1]   = DATA_REQUEST_IN; // R20
            end
            default: nxt_status = `FDCS_STATUS_RST;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            status_ff <= `FDCS_STATUS_RST; // R09
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Head settle delay, bypassed when the test input is low.
    fdcs_settle #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk   (CLK_SYS),
        .srst  (SRST),
        .start (SETTLE_REQ),
        .skip  (!TEST_IN),
        .done  (SETTLE_DONE)
    ); // R21

    assign S_AXI_AWREADY         = awready_ff;
    assign S_AXI_WREADY          = awready_ff;
    assign S_AXI_BVALID          = bvalid_ff;
    assign S_AXI_BRESP           = bresp_ff;
    assign S_AXI_ARREADY         = arready_ff;
    assign S_AXI_RVALID          = rvalid_ff;
    assign S_AXI_RRESP           = rresp_ff;
    assign S_AXI_RDATA           = rdata_ff;
    assign CMD_START             = start_ff;
    assign CMD_CODE              = cmd_ff;
    assign CMD_ABORT             = abort_ff;
    assign BUSY_OUT              = busy_ff;
    assign HEAD_LOAD_OUT         = ctrl_ff[`FDCS_CTRL_HLD];
    assign INTERRUPT_REQUEST_OUT = irq_ff;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    property p_reject_busy;
        (cmd_wr && busy_ff && !is_force) |=> !CMD_START && CMD_CODE == $past(CMD_CODE);
    endproperty
    a_reject_busy: assert property (p_reject_busy) else $error("command taken while busy"); // R01

    property p_abort;
        (force_acc && busy_ff) |=> CMD_ABORT ##1 !CMD_ABORT;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on forced interrupt"); // R02

    property p_irq_clear;
        (stat_rd && !irq_set) |=> !INTERRUPT_REQUEST_OUT;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status read left irq set"); // R03

    property p_busy_bit;
        BUSY_OUT |-> ##1 (status_ff[0] || class_ff == CL_FORCED);
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit not shown"); // R04

    property p_force_busy;
        force_acc |=> !BUSY_OUT;
    endproperty
    a_force_busy: assert property (p_force_busy) else $error("busy not cleared"); // R05

    property p_force_idle;
        (force_acc && !busy_ff) |-> ##2 (status_ff[4:3] == 2'b00 && !status_ff[0]);
    endproperty
    a_force_idle: assert property (p_force_idle) else $error("idle forced layout wrong"); // R06

    property p_not_ready;
        !$past(SRST) |-> status_ff[7] == !$past(READY_IN);
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("not ready bit wrong"); // R09

    property p_drq;
        (!$past(SRST) && $past(class_ff) != CL_SEEK && $past(class_ff) != CL_FORCED)
            |-> status_ff[1] == $past(DATA_REQUEST_IN);
    endproperty
    a_drq: assert property (p_drq) else $error("data request bit wrong"); // R20

    property p_busy_latency;
        cmd_start |-> ##[1:BUSY_DD] BUSY_OUT;
    endproperty
    a_busy_latency: assert property (p_busy_latency) else $error("busy set too late"); // R15

    property p_verify_clear;
        (cmd_start && !VERIFY_FAIL) |=> !f_verify;
    endproperty
    a_verify_clear: assert property (p_verify_clear) else $error("seek error not cleared"); // R13

    property p_settle_skip;
        (SETTLE_REQ && !TEST_IN) |=> SETTLE_DONE;
    endproperty
    a_settle_skip: assert property (p_settle_skip) else $error("settle not skipped"); // R21

    c_force_busy: cover property (force_acc && busy_ff);
    c_force_idle: cover property (force_acc && !busy_ff);
    c_irq_read:   cover property (INTERRUPT_REQUEST_OUT && stat_rd);
    c_done:       cover property (BUSY_OUT && CMD_DONE ##1 INTERRUPT_REQUEST_OUT);

endmodule

// ==== fdcs_seq_model.sv ====
`timescale 1ns/10ps
// Sequencer and drive model: finishes each started command after a short run, unless hang is set or it is aborted.
module fdcs_seq_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       srst,
    // Bench controls: raise all events, or never finish.
    input  wire logic       ev_en,
    input  wire logic       hang,
    // From the controller.
    input  wire logic       cmd_start,
    input  wire logic       cmd_abort,
    // Event pulses and completion.
    output logic [5:0]      events,
    output logic            cmd_done
);
    logic [3:0] cnt_ff;

    // An abort drops the pending completion.
    always_ff @(posedge clk) begin
        if (srst || cmd_abort) begin
            cnt_ff <= 4'h0;
        end else if (cmd_start) begin
            cnt_ff <= 4'h6;
        end else if (cnt_ff != 4'h0 && !(hang && cnt_ff == 4'h2)) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            events   <= 6'h00;
            cmd_done <= 1'b0;
        end else begin
            events   <= (cnt_ff == 4'h3 && ev_en) ? 6'h3F : 6'h00;
            cmd_done <= cnt_ff == 4'h2 && !hang;
        end
    end
endmodule

// ==== fdc_status_and_force_interrupt_tb.sv ====
`timescale 1ns/10ps
module fdc_status_and_force_interrupt_tb;
    localparam int SETTLE = 20;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, code;
    logic [31:0] wdat = 32'h0, rdata, got;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        rdy = 1'b1, wp = 1'b1, tr0 = 1'b1, ip = 1'b1, hlt = 1'b0;
    logic        test_in = 1'b1, drq = 1'b0, sreq = 1'b0, ev_en = 1'b0, hang = 1'b0;
    logic [5:0]  ev;
    logic        done, start, abort, sdone, busy, hld, irq;
    int          fails = 0, check_count = 0, aborts = 0, i;
    logic [7:0]  t_code [8] = '{8'h10, 8'h10, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'hF0, 8'h80};
    logic        t_ev [8]   = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0]  t_st [8]   = '{8'h58, 8'h40, 8'h3E, 8'h7E, 8'h1E, 8'h06, 8'h62, 8'h02};

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (abort === 1'b1) aborts++;
    end

    fdcs_status_ctrl #(.SETTLE_CYCLES(SETTLE)) u_dut (
        .CLK_SYS(clk), .SRST(srst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdat), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready),
        .READY_IN(rdy), .WRITE_PROTECT_IN(wp), .TRACK_ZERO_IN(tr0),
        .INDEX_PULSE_IN(ip), .HEAD_LOAD_TIMING_IN(hlt), .TEST_IN(test_in),
        .DATA_REQUEST_IN(drq), .VERIFY_FAIL(ev[0]), .CRC_ERROR(ev[1]),
        .RECORD_NOT_FOUND(ev[2]), .LOST_DATA(ev[3]), .DELETED_MARK(ev[4]),
        .WRITE_FAULT(ev[5]), .CMD_DONE(done), .SETTLE_REQ(sreq),
        .CMD_START(start), .CMD_CODE(code), .CMD_ABORT(abort), .SETTLE_DONE(sdone),
        .BUSY_OUT(busy), .HEAD_LOAD_OUT(hld), .INTERRUPT_REQUEST_OUT(irq)
    );

    fdcs_seq_model u_seq (
        .clk(clk), .srst(srst), .ev_en(ev_en), .hang(hang),
        .cmd_start(start), .cmd_abort(abort), .events(ev), .cmd_done(done)
    );

    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tmo();
        fails++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        end_of_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdat <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awv <= 1'b0;
            if (wready === 1'b1) wv <= 1'b0;
            n++;
            if (n > 50) tmo();
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arv <= 1'b0;
            n++;
            if (n > 50) tmo();
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk(rresp, er);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, 2'b00, d);
        chk(d, e);
    endtask

    task automatic cmd(input logic [7:0] c);
        int n;
        n = 0;
        wr(8'h00, {24'h0, c}, 2'b00);
        while (busy !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 12) tmo();
        end
        chk(busy, 1'b1);
        chk(code, c);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 60) tmo();
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic settle(input logic t, input int e);
        int n;
        n = 0;
        @(posedge clk);
        test_in <= t;
        sreq <= 1'b1;
        @(posedge clk);
        sreq <= 1'b0;
        while (sdone !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 100) tmo();
        end
        chk(n, e);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rdc(8'h04, 32'h00);
        rdy <= 1'b0;
        wp <= 1'b0;
        tr0 <= 1'b0;
        ip <= 1'b0;
        hlt <= 1'b1;
        wr(8'h08, 32'h3, 2'b00);
        rdc(8'h08, 32'h3);
        rdc(8'h04, 32'hE6);
        chk(hld, 1'b1);
        rdy <= 1'b1;
        tr0 <= 1'b1;
        ip <= 1'b1;
        hlt <= 1'b0;
        drq <= 1'b1;
        wr(8'h08, 32'h1, 2'b00);
        wr(8'h0C, 32'h0, 2'b10);
        rd(8'h0C, 2'b10, got);
        chk(got, 32'h0);
        $display("Test pins and map done");
        for (i = 0; i < 8; i++) begin
            ev_en <= t_ev[i];
            cmd(t_code[i]);
            wait_irq();
            rdc(8'h04, {24'h0, t_st[i]});
        end
        cmd(8'hF0);
        wait_irq();
        rdc(8'h04, 32'h42);
        $display("Test class layouts done");
        hang <= 1'b1;
        ev_en <= 1'b0;
        cmd(8'hC0);
        wr(8'h00, 32'h10, 2'b00);
        rdc(8'h00, 32'hC0);
        rdc(8'h04, 32'h03);
        wr(8'h00, 32'hD8, 2'b00);
        repeat (2) @(posedge clk);
        chk(busy, 1'b0);
        chk(irq, 1'b1);
        chk(aborts, 1);
        rdc(8'h04, 32'h02);
        @(posedge clk);
        chk(irq, 1'b0);
        hang <= 1'b0;
        $display("Test forced while busy done");
        ev_en <= 1'b1;
        cmd(8'h10);
        wait_irq();
        tr0 <= 1'b0;
        ip <= 1'b0;
        wr(8'h00, 32'hD8, 2'b00);
        rdc(8'h04, 32'h46);
        @(posedge clk);
        chk(irq, 1'b0);
        wr(8'h00, 32'hD8, 2'b00);
        wait_irq();
        wr(8'h00, 32'hD0, 2'b00);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        ip <= 1'b1;
        wr(8'h00, 32'hD4, 2'b00);
        ip <= 1'b0;
        wait_irq();
        rdc(8'h04, 32'h46);
        wr(8'h00, 32'hD2, 2'b00);
        rdy <= 1'b0;
        wait_irq();
        rdc(8'h04, 32'hC6);
        wr(8'h00, 32'hD1, 2'b00);
        rdy <= 1'b1;
        wait_irq();
        rdc(8'h04, 32'h46);
        chk(irq, 1'b0);
        $display("Test forced while idle done");
        settle(1'b0, 1);
        settle(1'b1, SETTLE + 1);
        $display("Test settle done");
        end_of_test();
    end
endmodule
